// ### hdl/sapr_ctrl.v
// Conversion sequencing and parallel three-state readout of the converter
// How it works
// R01: On completion raise busy, present 12-bit result
// R02: Previous result readable early in conversion
// R03: Host avoids reads from window end to busy
// R04: Host best avoids reads during conversion
// R05: Convert falls starts; convert rises enables output
// R06: Conversion and busy low last at most 2.2us
// R07: New data valid within 3.2us of start
// R08: Busy falls within 25ns of start
// R09: Data valid at least 35ns before busy rises
// R10: Host spaces conversion starts 4us apart
// R11: Convert low 40ns during busy aborts, resets
// R12: After abort host holds convert high 4us
// R13: Hosts ignoring busy abort at initialisation
// R14: Host convert pulse 40ns to 1.75us
// R15: Drive bus only when convert high, select low
// R16: Results are two's complement
// R17: Select and convert ORed, level sensitive start
// R18: Busy stays high while idle, after abort too
`include "sapr_map.vh"
module sapr_ctrl (
	// Clock and reset
	input  wire                    sys_clk_i,
	input  wire                    rst_n_i,
	// Host control pins
	input  wire                    cs_n_i,
	input  wire                    rd_conv_n_i,
	output wire                    busy_n_o,
	// Parallel result bus, data and enable per pin
	output reg  [`SAPR_DATA_W-1:0] result_data_bus_o,
	output wire [`SAPR_DATA_W-1:0] result_data_bus_oe_o,
	// Converter core sample stream (two's complement)
	input  wire                    smp_valid_i,
	output wire                    smp_ready_o,
	input  wire [`SAPR_DATA_W-1:0] smp_data_i
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_CONV = 3'b010;
	localparam [2:0] ST_SETL = 3'b100;
	// Conversion share leaves room for output register and settle
	localparam integer CONV_INT =
		`SAPR_T_CONV_CYC - `SAPR_T_DV_BUSY_CYC - 2;
	localparam integer PREV_INT = `SAPR_T_PREV_CYC - 1;
	localparam integer DVB_INT  = `SAPR_T_DV_BUSY_CYC;
	localparam integer ABT_INT  = `SAPR_T_ABORT_CYC - 1;
	// Counts cut to the counter width on purpose
	localparam [`SAPR_CNT_W-1:0] CONV_CYC = CONV_INT[`SAPR_CNT_W-1:0];
	localparam [`SAPR_CNT_W-1:0] PREV_CYC = PREV_INT[`SAPR_CNT_W-1:0];
	localparam [`SAPR_CNT_W-1:0] DVB_CYC  = DVB_INT[`SAPR_CNT_W-1:0];
	localparam [`SAPR_CNT_W-1:0] ABT_CYC  = ABT_INT[`SAPR_CNT_W-1:0];

	reg  [1:0]              rst_sync_q;
	wire                    rst_n;
	reg  [1:0]              cs_sync_q;
	reg  [1:0]              rc_sync_q;
	reg                     start_lvl_q;
	reg                     rc_prev_q;
	reg  [2:0]              state_q;
	reg  [2:0]              state_d;
	reg  [`SAPR_CNT_W-1:0]  cnt_q;
	reg  [`SAPR_CNT_W-1:0]  cnt_d;
	reg  [`SAPR_CNT_W-1:0]  abt_q;
	reg                     prev_ok_q;
	reg                     abort_hold_q;
	reg                     abt_arm_q;
	reg  [`SAPR_DATA_W-1:0] result_q;
	reg  [`SAPR_DATA_W-1:0] result_d;
	wire                    cs_n;
	wire                    rc_n;
	wire                    start_lvl;
	wire                    start;
	wire                    abort;
	wire                    fifo_valid;
	wire                    fifo_pop;
	wire [`SAPR_DATA_W-1:0] fifo_data;
	wire                    drive_en;

	// Reset release through two flip-flops
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Pin synchronisers, idle high
	always @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cs_sync_q <= 2'b11;
			rc_sync_q <= 2'b11;
		end else begin
			cs_sync_q <= {cs_sync_q[0], cs_n_i};
			rc_sync_q <= {rc_sync_q[0], rd_conv_n_i};
		end
	end
	assign cs_n = cs_sync_q[1];
	assign rc_n = rc_sync_q[1];

	// Start when both lines are low, whichever falls last
	assign start_lvl = ~(cs_n | rc_n); // [R17]
	assign start = start_lvl & ~start_lvl_q & ~abort_hold_q
		& (state_q == ST_IDLE); // [R05]

	// Convert held low long enough while busy aborts
	assign abort = (state_q != ST_IDLE) && ~rc_n && abt_arm_q
		&& (abt_q == ABT_CYC) && ~abort_hold_q; // [R11]

	// Sample sequencing
	always @* begin
		state_d  = state_q;
		cnt_d    = cnt_q;
		result_d = result_q;
		case (state_q)
			ST_IDLE: begin
				if (start) begin
					state_d = ST_CONV; // [R08]
					cnt_d   = {`SAPR_CNT_W{1'b0}};
				end
			end
			ST_CONV: begin
				cnt_d = cnt_q + 1'b1;
				if (abort) begin
					state_d = ST_IDLE;
				end else if (cnt_q >= CONV_CYC && fifo_valid) begin
					result_d = fifo_data; // [R01] [R16]
					state_d  = ST_SETL;
					cnt_d    = {`SAPR_CNT_W{1'b0}};
				end
			end
			ST_SETL: begin
				cnt_d = cnt_q + 1'b1;
				if (abort) begin
					state_d = ST_IDLE;
				end else if (cnt_q == DVB_CYC) begin
					state_d = ST_IDLE; // [R09] [R06] [R07]
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end
	assign fifo_pop = (state_q == ST_CONV) && ~abort
		&& (cnt_q >= CONV_CYC) && fifo_valid;

	// State, counters and result register
	always @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_q      <= ST_IDLE;
			cnt_q        <= {`SAPR_CNT_W{1'b0}};
			abt_q        <= {`SAPR_CNT_W{1'b0}};
			result_q     <= {`SAPR_DATA_W{1'b0}};
			start_lvl_q  <= 1'b0;
			rc_prev_q    <= 1'b1;
			prev_ok_q    <= 1'b1;
			abort_hold_q <= 1'b0;
			abt_arm_q    <= 1'b0;
		end else begin
			state_q     <= state_d;
			cnt_q       <= cnt_d;
			result_q    <= result_d;
			start_lvl_q <= start_lvl;
			rc_prev_q   <= rc_n;
			// Low-time counter for abort, restarts on each fall
			if (rc_n || (rc_prev_q && ~rc_n)) begin
				abt_q <= {`SAPR_CNT_W{1'b0}};
			end else if (abt_q != ABT_CYC) begin
				abt_q <= abt_q + 1'b1;
			end
			// Abort arms only on a fall seen mid-conversion,
			// so a long start pulse never aborts its own start
			if (rc_n || (state_q == ST_IDLE)) begin
				abt_arm_q <= 1'b0;
			end else if (rc_prev_q) begin
				abt_arm_q <= 1'b1; // [R11]
			end
			// After abort, wait for convert to return high
			if (abort) begin
				abort_hold_q <= 1'b1; // [R18]
			end else if (rc_n) begin
				abort_hold_q <= 1'b0;
			end
			// Previous data stays valid for the early window
			if (start) begin
				prev_ok_q <= 1'b1;
			end else if (state_q == ST_CONV && cnt_q == PREV_CYC) begin
				prev_ok_q <= 1'b0; // [R02]
			end else if (state_q == ST_IDLE) begin
				prev_ok_q <= 1'b1;
			end
		end
	end

	// Busy low only while converting or settling
	assign busy_n_o = (state_q == ST_IDLE); // [R18] [R01]

	// Output enable only with convert high and select low
	assign drive_en = rc_n & ~cs_n; // [R15] [R05]
	assign result_data_bus_oe_o = {`SAPR_DATA_W{drive_en}};

	// Output data register; invalid window shows zero
	always @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			result_data_bus_o <= {`SAPR_DATA_W{1'b0}};
		end else if (state_q == ST_CONV && !prev_ok_q) begin
			result_data_bus_o <= {`SAPR_DATA_W{1'b0}};
		end else begin
			result_data_bus_o <= result_q; // [R02]
		end
	end

	// Sample buffer between converter core and result register
	sapr_fifo #(
		.WIDTH (`SAPR_DATA_W),
		.DEPTH (`SAPR_FIFO_DEPTH),
		.AW    (4)
	) u_fifo (
		.clk_i       (sys_clk_i),
		.rst_n_i     (rst_n),
		.in_valid_i  (smp_valid_i),
		.in_ready_o  (smp_ready_o),
		.in_data_i   (smp_data_i),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (fifo_data)
	);
endmodule

// ### hdl/sapr_fifo.v
// Parameterised synchronous FIFO with valid/ready on both sides
module sapr_fifo #(
	parameter WIDTH = 12,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// Clock and reset
	input  wire             clk_i,
	input  wire             rst_n_i,
	// Fill side
	input  wire             in_valid_i,
	output wire             in_ready_o,
	input  wire [WIDTH-1:0] in_data_i,
	// Drain side
	output wire             out_valid_o,
	input  wire             out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW:0]      wr_q;
	reg  [AW:0]      rd_q;
	wire             full;
	wire             empty;
	wire             push;
	wire             pop;

	// Honest full and empty from extended pointers
	assign empty = (wr_q == rd_q);
	assign full  = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
	assign in_ready_o  = ~full;
	assign out_valid_o = ~empty;
	assign push = in_valid_i & ~full;
	assign pop  = out_ready_i & ~empty;
	assign out_data_o = mem[rd_q[AW-1:0]];

	// Storage write
	always @(posedge clk_i) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data_i;
		end
	end

	// Pointer update
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule

// ### pkg/sapr_map.vh
// Timing constants and widths for the parallel-readout converter control
`ifndef SAPR_MAP_VH
`define SAPR_MAP_VH
`define SAPR_CLK_PERIOD_NS   5
`define SAPR_DATA_W          12
`define SAPR_FIFO_DEPTH      16
// Times in ns as printed, cycle counts derived at 5 ns
`define SAPR_T_CONV_NS       2200
`define SAPR_T_CONV_CYC      (`SAPR_T_CONV_NS / `SAPR_CLK_PERIOD_NS)
`define SAPR_T_PREV_NS       2200
`define SAPR_T_PREV_CYC      (`SAPR_T_PREV_NS / `SAPR_CLK_PERIOD_NS)
`define SAPR_T_DV_BUSY_NS    35
`define SAPR_T_DV_BUSY_CYC   ((`SAPR_T_DV_BUSY_NS + `SAPR_CLK_PERIOD_NS - 1) / `SAPR_CLK_PERIOD_NS)
`define SAPR_T_ABORT_NS      40
`define SAPR_T_ABORT_CYC     ((`SAPR_T_ABORT_NS + `SAPR_CLK_PERIOD_NS - 1) / `SAPR_CLK_PERIOD_NS)
`define SAPR_CNT_W           9
`endif

// ### test/sapr_ctrl_sva.sv
// Checker for busy, readout and abort timing
module sapr_ctrl_sva (
	// Clock, reset and pins
	input logic        sys_clk_i,
	input logic        rst_n_i,
	input logic        cs_n_i,
	input logic        rd_conv_n_i,
	input logic        busy_n_o,
	input logic [11:0] result_data_bus_o,
	input logic [11:0] result_data_bus_oe_o,
	input logic        smp_ready_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [8:0] low_q;
	// Cycles spent with busy low
	always @(posedge sys_clk_i or negedge rst_n_i)
		if (!rst_n_i) low_q <= 9'h000;
		else low_q <= busy_n_o ? 9'h000 : low_q + 9'h001;
	a_busy_fall_fast: assert property (
		!cs_n_i && $fell(rd_conv_n_i) && busy_n_o && $past(rd_conv_n_i, 2)
		|-> ##[1:5] !busy_n_o) else $error("busy fell late");
	a_busy_max_len: assert property (low_q <= 9'h1B8)
		else $error("busy low too long");
	a_prev_data_hold: assert property (
		!busy_n_o && low_q < 9'h122 |-> $stable(result_data_bus_o))
		else $error("previous result lost early");
	a_data_before_busy: assert property (
		$rose(busy_n_o) |-> $past(result_data_bus_o, 7) == result_data_bus_o)
		else $error("result changed too near busy rise");
	a_drive_on: assert property (
		(rd_conv_n_i && !cs_n_i)[*6] |-> &result_data_bus_oe_o)
		else $error("bus not driven");
	a_drive_off: assert property (
		(!rd_conv_n_i || cs_n_i)[*6] |-> result_data_bus_oe_o == 12'h000)
		else $error("bus driven while off");
	a_abort_ends: assert property (
		!busy_n_o && $fell(rd_conv_n_i) ##1 (!rd_conv_n_i)[*8]
		|-> ##[0:6] busy_n_o) else $error("abort ignored");
	a_idle_busy_high: assert property (
		(busy_n_o && (rd_conv_n_i || cs_n_i))[*4] |=> busy_n_o)
		else $error("busy fell while idle");
	c_done: cover property ($rose(busy_n_o));
	c_abort: cover property (!busy_n_o && $fell(rd_conv_n_i));
	c_full: cover property (!smp_ready_o);
endmodule
bind sapr_ctrl sapr_ctrl_sva chk_u (.sys_clk_i, .rst_n_i, .cs_n_i,
	.rd_conv_n_i, .busy_n_o, .result_data_bus_o, .result_data_bus_oe_o,
	.smp_ready_o);

// ### test/sapr_host.sv
// Host model driving the select and convert pins
module sapr_host (
	// Clock in, pins out
	input  logic clk_i,
	output logic cs_n_o,
	output logic rd_conv_n_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// Both pins idle high
	initial begin
		cs_n_o = 1'b1;
		rd_conv_n_o = 1'b1;
	end
	// Convert pulse, select optionally lowered last
	task automatic conv(input int low_cyc, input bit cs_last);
		@(posedge clk_i) #1;
		cs_n_o = cs_last;
		rd_conv_n_o = 1'b0;
		if (cs_last) begin
			repeat (4) @(posedge clk_i);
			#1 cs_n_o = 1'b0;
		end
		repeat (low_cyc) @(posedge clk_i);
		#1 rd_conv_n_o = 1'b1;
	endtask
	// Full cycle time before any next start
	task automatic rest();
		repeat (800) @(posedge clk_i);
	endtask
endmodule

// ### test/sar_adc_parallel_readout_test.sv
// Self-checking bench for conversion sequencing and readout
module sar_adc_parallel_readout_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic        sys_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        cs_n, rc_n, busy_n, smp_ready;
	logic        smp_valid = 1'b0;
	logic [11:0] bus, oe;
	logic [11:0] smp_data = 12'h000;
	logic [11:0] prev = 12'h000;
	int          num_errors = 0;
	int          tests_run = 0;
	// 200 MHz clock
	always #2.5 sys_clk_i = ~sys_clk_i;
	sapr_host host_u (.clk_i(sys_clk_i), .cs_n_o(cs_n), .rd_conv_n_o(rc_n));
	sapr_ctrl dut_u (.sys_clk_i, .rst_n_i, .cs_n_i(cs_n), .rd_conv_n_i(rc_n),
		.busy_n_o(busy_n), .result_data_bus_o(bus),
		.result_data_bus_oe_o(oe), .smp_valid_i(smp_valid),
		.smp_ready_o(smp_ready), .smp_data_i(smp_data));
	task automatic check(input string what, input logic [11:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Sample words, both signs of two's complement
	function automatic logic [11:0] word(input int i);
		return 12'h7FF + 12'(i) * 12'h123;
	endfunction
	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic wait_busy(input logic v, input int n);
		while (busy_n !== v && n > 0) begin
			@(posedge sys_clk_i) #1;
			n = n - 1;
		end
	endtask
	task automatic push(input logic [11:0] w);
		@(posedge sys_clk_i) #1;
		smp_valid = 1'b1;
		smp_data = w;
		while (smp_ready !== 1'b1) @(posedge sys_clk_i) #1;
		@(posedge sys_clk_i) #1 smp_valid = 1'b0;
	endtask
	task automatic t_reset();
		repeat (12) @(posedge sys_clk_i);
		#1 rst_n_i = 1'b1;
		repeat (8) @(posedge sys_clk_i);
		#1 check("reset busy", busy_n, 1'b1);
		check("reset drive", oe, 12'h000);
		for (int i = 0; i < 16; i++) push(word(i));
		check("fifo full", smp_ready, 1'b0);
		$display("reset and fill done");
	endtask
	task automatic t_conv(input int i, input bit cs_last);
		host_u.conv(8, cs_last);
		wait_busy(1'b0, 4);
		check("busy start", busy_n, 1'b0);
		repeat (200) @(posedge sys_clk_i);
		#1 check("prev data", bus, prev);
		check("drive early", oe, 12'hFFF);
		wait_busy(1'b1, 460);
		check("busy end", busy_n, 1'b1);
		prev = word(i);
		check("new data", bus, prev);
		host_u.rest();
		$display("conversion %0d done", i);
	endtask
	task automatic t_abort();
		host_u.conv(8, 1'b0);
		repeat (100) @(posedge sys_clk_i);
		host_u.conv(10, 1'b0);
		wait_busy(1'b1, 6);
		check("abort busy", busy_n, 1'b1);
		check("kept data", bus, prev);
		host_u.rest();
		check("idle busy", busy_n, 1'b1);
		$display("abort done");
	endtask
	// Main sequence
	initial begin
		t_reset();
		for (int i = 0; i < 15; i++) t_conv(i, i == 3);
		t_abort();
		t_conv(15, 1'b0);
		stop_test();
	end
	// Watchdog: about two and a half times the expected run
	initial begin
		#250us;
		num_errors++;
		stop_test();
	end
endmodule
